// ==== core/cfx_pkg.sv ====
// Purpose: Shared constants for the call and file-operation execution block.
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit data.
// Notes:   Opcode encodings are defined here once and used by the execution unit.

package cfx_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int CFX_PC_W      = 13;
	localparam int CFX_INSN_W    = 14;
	localparam int CFX_DATA_W    = 8;
	localparam int CFX_FADDR_W   = 7;
	localparam int CFX_LIT_W     = 11;
	localparam int CFX_STACK_DEPTH = 8;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CFX_DEST_BIT   = 7;
	localparam int CFX_OPC_HI     = 13;
	localparam int CFX_CALL_OPC_LO = 11;
	localparam int CFX_FILE_OPC_LO = 8;
	localparam int CFX_CLR_OPC_LO  = 7;
	localparam int CFX_LATCH_LO   = 3;
	localparam int CFX_LATCH_HI   = 4;

	// ****************************************************************
	// Opcode patterns
	// ****************************************************************
	localparam logic [2:0]  CFX_OP_CALL    = 3'h4;
	localparam logic [5:0]  CFX_OP_COMPL   = 6'h09;
	localparam logic [5:0]  CFX_OP_DECR    = 6'h03;
	localparam logic [6:0]  CFX_OP_CLR     = 7'h03;
	localparam logic [6:0]  CFX_OP_CLEAR_WORK_OP    = 7'h02;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [12:0] CFX_PC_RST     = 13'h0000;
	localparam logic [7:0]  CFX_W_RST      = 8'h00;
	localparam logic        CFX_Z_RST      = 1'b0;
	localparam logic [7:0]  CFX_ZERO_BYTE  = 8'h00;

	typedef enum logic [2:0] {
		CFX_ST_FETCH = 3'b001,
		CFX_ST_EXEC  = 3'b010,
		CFX_ST_CALL2 = 3'b100
	} cfx_state_type;

endpackage : cfx_pkg

// ==== core/cfx_stack.sv ====
// Purpose: Hardware return stack holding program counter values.
// Assumes: Circular stack; overflow wraps silently.
// Notes:   Top of stack comes out of a register.

`timescale 1ns/100ps
`default_nettype none

module cfx_stack
	import cfx_pkg::*;
#(
	parameter int DEPTH = CFX_STACK_DEPTH,
	parameter int WIDTH = CFX_PC_W
) (
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	input  wire logic               push,
	input  wire logic [WIDTH-1:0]   push_data,
	output logic      [WIDTH-1:0]   stack_top
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    ptr_q;
	logic [PW-1:0]    ptr_d;
	logic [WIDTH-1:0] top_d;

	// The top register reads the entry under the pointer and takes a pushed value directly, so a push shows on the next cycle.
	always_comb begin
		ptr_d = ptr_q;
		top_d = mem_q[ptr_q];
		if (push) begin
			ptr_d = ptr_q + PW'(1);
			top_d = push_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ptr_q     <= '0;
			stack_top <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			ptr_q     <= ptr_d;
			stack_top <= top_d;
			if (push) begin
				mem_q[ptr_d] <= push_data;
			end
		end
	end

endmodule : cfx_stack

`default_nettype wire

// ==== core/cfx_exec.sv ====
// Purpose: Executes subroutine call and file register operations.
// Assumes: File register read data is valid combinationally for the addressed file.
// Notes:   One instruction cycle is one clock; a call spends a second cycle.

`timescale 1ns/100ps
`default_nettype none

module cfx_exec
	import cfx_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	input  wire logic                    insn_valid,
	input  wire logic [CFX_INSN_W-1:0]   insn,
	input  wire logic [7:0]              pc_high_latch,
	input  wire logic [CFX_DATA_W-1:0]   file_rdata,
	output logic                         insn_ready,
	output logic      [CFX_FADDR_W-1:0]  file_addr,
	output logic                         file_we,
	output logic      [CFX_DATA_W-1:0]   file_wdata,
	output logic      [CFX_PC_W-1:0]     program_counter,
	output logic      [CFX_PC_W-1:0]     stack_top,
	output logic      [CFX_DATA_W-1:0]   work_reg,
	output logic                         zero_flag,
	output logic                         zero_we
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	function automatic logic is_file_op(input logic [CFX_INSN_W-1:0] w, input logic [5:0] op);
		return w[CFX_OPC_HI:CFX_FILE_OPC_LO] == op;
	endfunction : is_file_op

	function automatic logic is_clear_op(input logic [CFX_INSN_W-1:0] w, input logic [6:0] op);
		return w[CFX_OPC_HI:CFX_CLR_OPC_LO] == op;
	endfunction : is_clear_op

	logic is_call;
	logic is_compl;
	logic is_decr;
	logic is_clr;
	logic is_clear_work_op;
	logic dest_file;
	logic take;

	always_comb begin
		is_call   = insn[CFX_OPC_HI:CFX_CALL_OPC_LO] == CFX_OP_CALL;
		is_compl  = is_file_op(insn, CFX_OP_COMPL);
		is_decr   = is_file_op(insn, CFX_OP_DECR);
		is_clr    = is_clear_op(insn, CFX_OP_CLR);
		is_clear_work_op   = is_clear_op(insn, CFX_OP_CLEAR_WORK_OP);
		dest_file = insn[CFX_DEST_BIT];
	end

	// ****************************************************************
	// Sequencer and program counter
	// ****************************************************************
	cfx_state_type               state_q;
	cfx_state_type               state_d;
	logic [CFX_PC_W-1:0]         pc_q;
	logic [CFX_PC_W-1:0]         pc_d;
	logic                        push;
	logic [CFX_PC_W-1:0]         ret_addr;

	// The word behind a call is refused, which stands in for the flushed prefetch of a real pipeline.
	assign insn_ready = state_q != CFX_ST_CALL2;
	assign take       = insn_valid && insn_ready;
	assign ret_addr   = pc_q + CFX_PC_W'(1);
	assign file_addr  = insn[CFX_FADDR_W-1:0];

	always_comb begin
		state_d = state_q;
		pc_d    = pc_q;
		push    = 1'b0;
		case (state_q)
			CFX_ST_FETCH, CFX_ST_EXEC: begin
				state_d = CFX_ST_FETCH;
				if (take) begin
					pc_d    = ret_addr;
					state_d = CFX_ST_EXEC;
					if (is_call) begin
						push    = 1'b1;
						pc_d[CFX_LIT_W-1:0] = insn[CFX_LIT_W-1:0];
						pc_d[CFX_PC_W-1:CFX_LIT_W] = pc_high_latch[CFX_LATCH_HI:CFX_LATCH_LO];
						state_d = CFX_ST_CALL2;
					end
				end
			end
			CFX_ST_CALL2: begin
				// A call spends this cycle as a flushed fetch, so the counter holds.
				state_d = CFX_ST_FETCH;
			end
			default: begin
				state_d = CFX_ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q <= CFX_ST_FETCH;
			pc_q    <= CFX_PC_RST;
		end else begin
			state_q <= state_d;
			pc_q    <= pc_d;
		end
	end

	// ****************************************************************
	// Working register, zero flag and file write
	// ****************************************************************
	logic [CFX_DATA_W-1:0]       w_q;
	logic [CFX_DATA_W-1:0]       w_d;
	logic                        z_q;
	logic                        z_d;
	logic                        fwe_q;
	logic                        fwe_d;
	logic [CFX_DATA_W-1:0]       fwd_q;
	logic [CFX_DATA_W-1:0]       fwd_d;
	logic                        zwe_q;
	logic                        zwe_d;
	logic [CFX_DATA_W-1:0]       result;

	always_comb begin
		w_d    = w_q;
		z_d    = z_q;
		fwe_d  = 1'b0;
		fwd_d  = fwd_q;
		zwe_d  = 1'b0;
		result = CFX_ZERO_BYTE;
		if (take) begin
			if (is_compl || is_decr) begin
				result = is_compl ? ~file_rdata : file_rdata - CFX_DATA_W'(1);
				if (dest_file) begin
					fwe_d = 1'b1;
					fwd_d = result;
				end else begin
					w_d = result;
				end
				z_d   = result == CFX_ZERO_BYTE;
				zwe_d = 1'b1;
			end else if (is_clr) begin
				// clear file
				// The destination bit is part of this opcode (set for clear file); the file is always written.
				fwe_d = 1'b1;
				fwd_d = CFX_ZERO_BYTE;
				z_d   = 1'b1;
				zwe_d = 1'b1;
			end else if (is_clear_work_op) begin
				w_d   = CFX_ZERO_BYTE;
				z_d   = 1'b1;
				zwe_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			w_q   <= CFX_W_RST;
			z_q   <= CFX_Z_RST;
			fwe_q <= 1'b0;
			fwd_q <= CFX_ZERO_BYTE;
			zwe_q <= 1'b0;
		end else begin
			w_q   <= w_d;
			z_q   <= z_d;
			fwe_q <= fwe_d;
			fwd_q <= fwd_d;
			zwe_q <= zwe_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// The write strobe trails the operand by one cycle, so the register file must keep the address it saw.
	assign program_counter = pc_q;
	assign work_reg        = w_q;
	assign zero_flag       = z_q;
	assign file_we         = fwe_q;
	assign file_wdata      = fwd_q;
	assign zero_we         = zwe_q;

	// ****************************************************************
	// Return stack
	// ****************************************************************

	cfx_stack #(
		.DEPTH (CFX_STACK_DEPTH),
		.WIDTH (CFX_PC_W)
	) u_stack (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.push      (push),
		.push_data (ret_addr),
		.stack_top (stack_top)
	);

endmodule : cfx_exec

`default_nettype wire

// ==== verif/cfx_exec_props.sv ====
// Purpose: Port-level checks for the call and file-operation block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every cfx_exec instance.
`timescale 1ns/100ps
`default_nettype none
module cfx_exec_chk
	import cfx_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        insn_valid,
	input wire logic [13:0] insn,
	input wire logic [7:0]  pc_high_latch,
	input wire logic [7:0]  file_rdata,
	input wire logic        insn_ready,
	input wire logic [6:0]  file_addr,
	input wire logic        file_we,
	input wire logic [7:0]  file_wdata,
	input wire logic [12:0] program_counter,
	input wire logic [12:0] stack_top,
	input wire logic [7:0]  work_reg,
	input wire logic        zero_flag,
	input wire logic        zero_we
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic tk  = insn_valid && insn_ready;
	wire logic cl  = tk && insn[13:11] == CFX_OP_CALL;
	wire logic cm  = tk && insn[13:8] == CFX_OP_COMPL;
	wire logic dc  = tk && insn[13:8] == CFX_OP_DECR;
	a_call_push: assert property (cl |=> stack_top == $past(program_counter) + 13'h0001)
		else $error("call return address wrong");
	a_call_gap: assert property (cl |=> !insn_ready ##1 insn_ready)
		else $error("call not two cycles");
	a_call_low: assert property (cl |=> program_counter[10:0] == $past(insn[10:0]))
		else $error("call low target wrong");
	a_call_high: assert property (cl |=> program_counter[12:11] == $past(pc_high_latch[4:3]))
		else $error("call high target wrong");
	a_compl_val: assert property (cm |=> ($past(insn[7]) ? file_wdata : work_reg) == ~$past(file_rdata))
		else $error("complement result wrong");
	a_clr_file: assert property (tk && insn[13:7] == CFX_OP_CLR |=> file_we && file_wdata == 8'h00 && zero_flag)
		else $error("clear file wrong");
	a_clr_work: assert property (tk && insn[13:7] == CFX_OP_CLEAR_WORK_OP |=> work_reg == 8'h00 && zero_flag)
		else $error("clear work wrong");
	a_decr_val: assert property (dc |=> ($past(insn[7]) ? file_wdata : work_reg) == $past(file_rdata) - 8'h01)
		else $error("decrement result wrong");
	a_zero_upd: assert property ((cm || dc) |=> zero_we && zero_flag == (($past(insn[7]) ? file_wdata : work_reg) == 8'h00))
		else $error("zero flag wrong");
	a_refuse_hold: assert property (!insn_ready |=> $stable(program_counter) && $stable(work_reg) && !file_we && !zero_we)
		else $error("refused word changed state");
	a_call_noflag: assert property (cl |=> !zero_we && !file_we)
		else $error("call touched flag or file");
endmodule : cfx_exec_chk
bind cfx_exec cfx_exec_chk chk_u (.sys_clk, .rst_b, .insn_valid, .insn, .pc_high_latch, .file_rdata, .insn_ready,
	.file_addr, .file_we, .file_wdata, .program_counter, .stack_top, .work_reg, .zero_flag, .zero_we);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the call and file-operation block.
// Assumes: Bench plays program memory and register file.
// Notes:   Each operation is followed by an idle cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        insn_valid = 1'b0;
	logic [13:0] insn = 14'h0000;
	logic [7:0]  pc_high_latch = 8'h00;
	logic [7:0]  file_rdata = 8'h00;
	logic        insn_ready, file_we, zero_flag, zero_we;
	logic [6:0]  file_addr;
	logic [7:0]  file_wdata, work_reg;
	logic [12:0] program_counter, stack_top;
	int          mismatches = 0;
	int          total_checks = 0;
	cfx_exec dut_u (.sys_clk, .rst_b, .insn_valid, .insn, .pc_high_latch, .file_rdata, .insn_ready,
		.file_addr, .file_we, .file_wdata, .program_counter, .stack_top, .work_reg, .zero_flag, .zero_we);
	initial forever #5 sys_clk = ~sys_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// One file operation; we tells whether the file or the work register takes the result.
	task automatic run_op(input logic [13:0] i, input logic [7:0] rd, input logic we, input logic [7:0] res,
		input logic z);
		logic [12:0] pc0;
		logic [7:0]  w0;
		@(posedge sys_clk);
		pc0 = program_counter;
		w0 = work_reg;
		insn_valid <= 1'b1;
		insn <= i;
		file_rdata <= rd;
		#1;
		chk(16'(file_addr), 16'(i[6:0]), "file address");
		@(posedge sys_clk);
		insn_valid <= 1'b0;
		#1;
		chk(16'(file_we), 16'(we), "file write strobe");
		chk(16'(we ? file_wdata : work_reg), 16'(res), "result value");
		if (we)
			chk(16'(work_reg), 16'(w0), "work register disturbed");
		chk(16'(zero_flag), 16'(z), "zero flag");
		chk(16'(zero_we), 16'h0001, "zero flag strobe");
		chk(16'(program_counter), 16'(pc0 + 13'h0001), "counter advance");
	endtask : run_op
	// A call, with a clear-work request held on during the refused second cycle.
	task automatic run_call(input logic [10:0] k, input logic [7:0] lat);
		logic [12:0] pc0;
		logic [7:0]  w0;
		@(posedge sys_clk);
		pc0 = program_counter;
		w0 = work_reg;
		insn_valid <= 1'b1;
		insn <= {3'b100, k};
		pc_high_latch <= lat;
		@(posedge sys_clk);
		insn <= 14'h0100;
		pc_high_latch <= ~lat;
		#1;
		chk(16'(program_counter), 16'({lat[4:3], k}), "call target");
		chk(16'(stack_top), 16'(pc0 + 13'h0001), "return address");
		chk(16'(insn_ready), 16'h0000, "second call cycle");
		chk(16'({file_we, zero_we}), 16'h0000, "call strobed file or flag");
		@(posedge sys_clk);
		insn_valid <= 1'b0;
		#1;
		chk(16'(work_reg), 16'(w0), "refused request ran");
		chk(16'(program_counter), 16'({lat[4:3], k}), "counter moved while refused");
		chk(16'(insn_ready), 16'h0001, "ready after call");
	endtask : run_call
	// A word that none of these operations decodes only moves the counter on.
	task automatic run_other(input logic [13:0] i);
		logic [12:0] pc0;
		logic [7:0]  w0;
		logic        z0;
		@(posedge sys_clk);
		pc0 = program_counter;
		w0 = work_reg;
		z0 = zero_flag;
		insn_valid <= 1'b1;
		insn <= i;
		@(posedge sys_clk);
		insn_valid <= 1'b0;
		#1;
		chk(16'({file_we, zero_we}), 16'h0000, "strobe on other word");
		chk(16'({zero_flag, work_reg}), 16'({z0, w0}), "state moved on other word");
		chk(16'(program_counter), 16'(pc0 + 13'h0001), "counter advance on other word");
	endtask : run_other
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk(16'(program_counter), 16'h0000, "counter after reset");
		run_op({6'h09, 1'b0, 7'h05}, 8'hff, 1'b0, 8'h00, 1'b1);
		run_op({6'h09, 1'b1, 7'h05}, 8'h5a, 1'b1, 8'ha5, 1'b0);
		run_op({6'h03, 1'b1, 7'h11}, 8'h01, 1'b1, 8'h00, 1'b1);
		run_op({6'h03, 1'b0, 7'h11}, 8'h00, 1'b0, 8'hff, 1'b0);
		run_call(11'h5a3, 8'h18);
		run_call(11'h7ff, 8'h08);
		run_op({7'h03, 7'h22}, 8'h77, 1'b1, 8'h00, 1'b1);
		run_op({6'h03, 1'b0, 7'h11}, 8'h05, 1'b0, 8'h04, 1'b0);
		run_op({7'h02, 7'h00}, 8'h77, 1'b0, 8'h00, 1'b1);
		run_other(14'h0000);
		summarize();
	end
	// The sequence needs well under a hundred cycles.
	initial begin
		repeat (500) @(posedge sys_clk);
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
